// ==== core/fsc_pkg.sv ====
package fsc_pkg;
  // frequency figures in 0.01 Hz units
  localparam int FREQ_W = 16;
  localparam int FRAC_W = 14;
  localparam int PCT_W = 8;
  localparam int CODE_W = 4;
  localparam int COMB_W = 6;
  localparam int NUM_CHAN = 10;

  // register byte offsets
  localparam logic [7:0] OFF_MOTOR = 8'h00;
  localparam logic [7:0] OFF_SRC = 8'h04;
  localparam logic [7:0] OFF_RANGE = 8'h08;
  localparam logic [7:0] OFF_COMBINE = 8'h0C;
  localparam logic [7:0] OFF_OFFSET = 8'h10;
  localparam logic [7:0] OFF_MAXF = 8'h14;
  localparam logic [7:0] OFF_PRESET = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;

  // field positions
  localparam int POS_AUX_SEL = 4;
  localparam int POS_RANGE_REF = 8;
  localparam int POS_ST_BANK = 16;
  localparam int POS_ST_SWITCH = 17;
  localparam int POS_ST_MOTOR_T = 18;

  // limits and reset values
  localparam logic [CODE_W-1:0] CODE_MAX = 4'h9;
  localparam logic [CODE_W-1:0] CODE_DIGITAL = 4'h0;
  localparam logic [PCT_W-1:0] PCT_MAX = 8'h96;
  localparam logic [PCT_W-1:0] PCT_FULL = 8'h64;
  localparam logic [COMB_W-1:0] COMB_MAX = 6'h22;
  localparam logic [FREQ_W-1:0] MAXF_MIN = 16'h1388;
  localparam logic [FREQ_W-1:0] MAXF_TOP = 16'hC350;
  localparam logic [FREQ_W-1:0] MAXF_RST = 16'h1388;
  localparam logic [FREQ_W-1:0] PRESET_RST = 16'h1388;
  localparam logic [FRAC_W-1:0] FRAC_FULL = 14'h2710;
  localparam logic [3:0] UNITS_MAX = 4'h4;
  localparam logic [3:0] TENS_DIV = 4'hA;

  typedef enum {FSC_MAIN_ONLY, FSC_COMBINE, FSC_SW_MAIN_AUX, FSC_SW_MAIN_COMB,
                FSC_SW_AUX_COMB} fsc_mode_t;
  typedef enum {FSC_OP_SUM, FSC_OP_DIFF, FSC_OP_MIN, FSC_OP_MAX} fsc_op_t;

  typedef struct packed {
    logic motor_bank_select;
    logic [CODE_W-1:0] main_source_select;
    logic [CODE_W-1:0] aux_source_select;
    logic aux_range_reference;
    logic [PCT_W-1:0] aux_range_percent;
    logic [COMB_W-1:0] source_combine_select;
    logic [FREQ_W-1:0] combine_offset_freq;
    logic [FREQ_W-1:0] max_output_freq;
    logic [FREQ_W-1:0] preset_freq;
  } fsc_cfg_t;

  localparam fsc_cfg_t CFG_RST = '{
    motor_bank_select: 1'b0, main_source_select: 4'h0, aux_source_select: 4'h0,
    aux_range_reference: 1'b0, aux_range_percent: 8'h00,
    source_combine_select: 6'h00, combine_offset_freq: 16'h0000,
    max_output_freq: MAXF_RST, preset_freq: PRESET_RST};
endpackage

// ==== core/fsc_arith.sv ====
`timescale 1ns/10ps
module fsc_arith #(
  parameter int FW = 16
) (
  // operands
  input wire logic [FW-1:0] x_freq,
  input wire logic signed [FW:0] y_freq,
  input wire logic [1:0] op_sel,
  // result
  output logic signed [FW+1:0] result
);
  wire logic signed [FW+1:0] xs = signed'({2'b00, x_freq});
  wire logic signed [FW+1:0] ys = signed'({y_freq[FW], y_freq});
  wire logic x_smaller = xs < ys;
  wire logic signed [FW+1:0] sum_w = xs + ys;
  wire logic signed [FW+1:0] diff_w = xs - ys;
  wire logic signed [FW+1:0] min_w = x_smaller ? xs : ys;
  wire logic signed [FW+1:0] max_w = x_smaller ? ys : xs;

  always_comb begin
    case (op_sel)
      2'h0: result = sum_w;
      2'h1: result = diff_w;
      2'h2: result = min_w;
      2'h3: result = max_w;
      default: result = sum_w;
    endcase
  end
endmodule

// ==== core/fsc_top.sv ====
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
module fsc_top #(
  parameter int FW = fsc_pkg::FREQ_W,
  parameter int NCH = fsc_pkg::NUM_CHAN
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // source channels, codes 1..9, full scale fraction
  input wire logic [NCH-1:1][fsc_pkg::FRAC_W-1:0] chan_frac,
  // digital channel up/down adjustment, signed
  input wire logic signed [FW:0] updown_adj,
  // terminals from pins
  input wire logic term_switch,
  input wire logic term_motor_en,
  input wire logic term_motor,
  // results
  output logic [FW-1:0] target_freq,
  output logic motor_bank,
  output logic motor2_param_bank
);
  if (FW != fsc_pkg::FREQ_W || NCH != fsc_pkg::NUM_CHAN) begin : g_check
    $error("fsc_top: FW and NCH must match the package widths");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  localparam logic [38:0] SCALE_DIV = 39'h00000F4240;

  function automatic logic [FW:0] scale(input logic [fsc_pkg::FRAC_W-1:0] frac,
                                        input logic [fsc_pkg::PCT_W-1:0] pct,
                                        input logic [FW:0] base);
    logic [38:0] prod;
    logic [38:0] quo;
    prod = 39'(frac) * 39'(pct) * 39'(base);
    quo = prod / SCALE_DIV;
    return quo[FW:0];
  endfunction

  function automatic logic [FW-1:0] clamp(input logic signed [FW+2:0] v,
                                          input logic [FW-1:0] top);
    logic signed [FW+2:0] t;
    t = signed'({3'b000, top});
    if (v < 0) begin
      return '0;
    end else if (v > t) begin
      return top;
    end
    return v[FW-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three flops, accepted when the last two agree
  logic [2:0] sync1_reg, sync2_reg, sync3_reg;
  logic [2:0] pins_reg, pins_next;
  wire logic [2:0] pin_raw = {term_motor_en, term_motor, term_switch};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      pins_reg <= '0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pins_reg <= pins_next;
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pins_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : pins_reg[i];
    end
  end

  wire logic sw_closed = pins_reg[0];
  wire logic motor_term = pins_reg[1];
  wire logic motor_term_en = pins_reg[2];

  ////////////////////////////////////////////////////////////////////////////
  // apb register file, zero wait states
  fsc_pkg::fsc_cfg_t cfg_reg, cfg_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_next;
  logic [FW-1:0] target_reg, target_next;
  logic bank_reg, bank_next;

  wire logic access = psel && penable;
  wire logic wr = access && pwrite;
  wire logic [3:0] w_units = 4'(pwdata[fsc_pkg::COMB_W-1:0] % fsc_pkg::TENS_DIV);
  wire logic [FW-1:0] w_freq = pwdata[FW-1:0];
  wire logic hit_motor = paddr == fsc_pkg::OFF_MOTOR;
  wire logic hit_src = paddr == fsc_pkg::OFF_SRC;
  wire logic hit_range = paddr == fsc_pkg::OFF_RANGE;
  wire logic hit_comb = paddr == fsc_pkg::OFF_COMBINE;
  wire logic hit_off = paddr == fsc_pkg::OFF_OFFSET;
  wire logic hit_maxf = paddr == fsc_pkg::OFF_MAXF;
  wire logic hit_pre = paddr == fsc_pkg::OFF_PRESET;
  wire logic hit_stat = paddr == fsc_pkg::OFF_STATUS;
  wire logic mapped = hit_motor | hit_src | hit_range | hit_comb | hit_off | hit_maxf |
                      hit_pre | hit_stat;
  // setting values outside their range are refused, old value kept
  wire logic ok_src = pwdata[3:0] <= fsc_pkg::CODE_MAX &&
                      pwdata[7:4] <= fsc_pkg::CODE_MAX;
  wire logic ok_range = pwdata[7:0] <= fsc_pkg::PCT_MAX;
  wire logic ok_comb = pwdata[fsc_pkg::COMB_W-1:0] <= fsc_pkg::COMB_MAX &&
                       w_units <= fsc_pkg::UNITS_MAX;
  wire logic ok_off = w_freq <= cfg_reg.max_output_freq;
  wire logic ok_maxf = w_freq >= fsc_pkg::MAXF_MIN &&
                       w_freq <= fsc_pkg::MAXF_TOP;
  wire logic ok_pre = w_freq <= cfg_reg.max_output_freq;
  wire logic bad_val = (hit_src && !ok_src) || (hit_range && !ok_range) ||
                       (hit_comb && !ok_comb) || (hit_off && !ok_off) ||
                       (hit_maxf && !ok_maxf) || (hit_pre && !ok_pre) || hit_stat;
  wire logic [31:0] status_w = {13'h0000, motor_term_en, sw_closed, bank_reg, target_reg};

  always_comb begin
    cfg_next = cfg_reg;
    if (wr && !bad_val) begin
      if (hit_motor) begin
        cfg_next.motor_bank_select = pwdata[0];
      end
      if (hit_src) begin
        cfg_next.main_source_select = pwdata[3:0];
        cfg_next.aux_source_select = pwdata[fsc_pkg::POS_AUX_SEL +: 4];
      end
      if (hit_range) begin
        cfg_next.aux_range_percent = pwdata[7:0];
        cfg_next.aux_range_reference = pwdata[fsc_pkg::POS_RANGE_REF];
      end
      if (hit_comb) begin
        cfg_next.source_combine_select = pwdata[fsc_pkg::COMB_W-1:0];
      end
      if (hit_off) begin
        cfg_next.combine_offset_freq = w_freq;
      end
      if (hit_maxf) begin
        cfg_next.max_output_freq = w_freq;
      end
      if (hit_pre) begin
        cfg_next.preset_freq = w_freq;
      end
    end
    // a lower max frequency pulls offset and preset down with it
    if (cfg_next.combine_offset_freq > cfg_next.max_output_freq) begin
      cfg_next.combine_offset_freq = cfg_next.max_output_freq;
    end
    if (cfg_next.preset_freq > cfg_next.max_output_freq) begin
      cfg_next.preset_freq = cfg_next.max_output_freq;
    end
  end

  always_comb begin
    prdata_next = prdata_reg;
    if (access && !pwrite) begin
      case (1'b1)
        hit_motor: prdata_next = 32'(cfg_reg.motor_bank_select);
        hit_src: prdata_next = 32'({cfg_reg.aux_source_select, cfg_reg.main_source_select});
        hit_range: prdata_next = 32'({cfg_reg.aux_range_reference, cfg_reg.aux_range_percent});
        hit_comb: prdata_next = 32'(cfg_reg.source_combine_select);
        hit_off: prdata_next = 32'(cfg_reg.combine_offset_freq);
        hit_maxf: prdata_next = 32'(cfg_reg.max_output_freq);
        hit_pre: prdata_next = 32'(cfg_reg.preset_freq);
        hit_stat: prdata_next = status_w;
        default: prdata_next = 32'h00000000;
      endcase
    end
  end

  assign pready = 1'b1;
  assign pslverr_next = access && (!mapped || (pwrite && bad_val));
  assign pslverr = pslverr_next;
  assign prdata = (access && !pwrite) ? prdata_next : prdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // motor bank selection
  // terminal wins whenever it is assigned, even if it agrees
  assign bank_next = motor_term_en ? motor_term : cfg_reg.motor_bank_select;

  ////////////////////////////////////////////////////////////////////////////
  // source decode
  localparam int CODE_W_L = fsc_pkg::CODE_W;
  wire logic [FW-1:0] maxf = cfg_reg.max_output_freq;
  wire logic [FW:0] maxf_x = {1'b0, maxf};
  wire logic [CODE_W_L-1:0] xcode = cfg_reg.main_source_select;
  wire logic [CODE_W_L-1:0] ycode = cfg_reg.aux_source_select;
  wire logic [fsc_pkg::FRAC_W-1:0] x_frac = (xcode == fsc_pkg::CODE_DIGITAL) ? '0 :
                                             chan_frac[xcode];
  wire logic [fsc_pkg::FRAC_W-1:0] y_frac = (ycode == fsc_pkg::CODE_DIGITAL) ? '0 :
                                             chan_frac[ycode];
  wire logic signed [FW+2:0] digital_w = signed'(19'(cfg_reg.preset_freq)) +
                                         signed'(19'(updown_adj));
  wire logic [FW-1:0] digital_f = clamp(digital_w, maxf);

  // analog, pulse and the other scaled sources share one path
  wire logic [FW-1:0] x_freq = (xcode == fsc_pkg::CODE_DIGITAL) ? digital_f :
                               FW'(scale(x_frac, fsc_pkg::PCT_FULL, maxf_x));
  // independent aux reads its code the same way as main
  wire logic [FW-1:0] y_indep = (ycode == fsc_pkg::CODE_DIGITAL) ? digital_f :
                                FW'(scale(y_frac, fsc_pkg::PCT_FULL, maxf_x));
  wire logic [FW:0] range_base = cfg_reg.aux_range_reference ? {1'b0, x_freq} : maxf_x;
  // superposed digital aux is only the up/down correction on top of main
  // one bit wider: 150 % of the top max frequency overflows a signed 17-bit value
  wire logic signed [FW+1:0] y_super = (ycode == fsc_pkg::CODE_DIGITAL) ?
    signed'((FW+2)'(updown_adj)) :
    signed'({1'b0, scale(y_frac, cfg_reg.aux_range_percent, range_base)});

  ////////////////////////////////////////////////////////////////////////////
  // combination
  wire logic [3:0] units = 4'(cfg_reg.source_combine_select % fsc_pkg::TENS_DIV);
  wire logic [3:0] tens = 4'(cfg_reg.source_combine_select / fsc_pkg::TENS_DIV);
  logic signed [FW+2:0] arith;

  // arithmetic runs one bit wider so a large superposed aux cannot wrap
  fsc_arith #(.FW(FW+1)) u_arith (
    .x_freq({1'b0, x_freq}),
    .y_freq(y_super),
    .op_sel(tens[1:0]),
    .result(arith)
  );

  wire logic signed [FW+2:0] comb_w = arith +
                                      signed'(19'(cfg_reg.combine_offset_freq));
  wire logic signed [FW+2:0] x_w = signed'(19'(x_freq));
  wire logic signed [FW+2:0] y_w = signed'(19'(y_indep));
  logic signed [FW+2:0] pick;

  always_comb begin
    case (units)
      4'h0: pick = x_w;
      4'h1: pick = comb_w;
      4'h2: pick = sw_closed ? y_w : x_w;
      4'h3: pick = sw_closed ? comb_w : x_w;
      4'h4: pick = sw_closed ? comb_w : y_w;
      default: pick = x_w;
    endcase
  end

  assign target_next = clamp(pick, maxf);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= fsc_pkg::CFG_RST;
      prdata_reg <= '0;
      target_reg <= '0;
      bank_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      prdata_reg <= prdata_next;
      target_reg <= target_next;
      bank_reg <= bank_next;
    end
  end

  assign target_freq = target_reg;
  assign motor_bank = bank_reg;
  // second motor follows the same bank select as motor one
  assign motor2_param_bank = bank_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_bank_terminal_wins: assert property (
    motor_term_en |=> motor_bank == $past(motor_term))
    else $error("motor bank does not follow assigned terminal");

  a_bank_setting_used: assert property (
    !motor_term_en |=> motor_bank == $past(cfg_reg.motor_bank_select))
    else $error("motor bank does not follow stored setting");

  a_bank_split: assert property (
    motor2_param_bank == motor_bank)
    else $error("second motor bank select disagrees with active bank");

  a_target_below_max: assert property (
    target_freq <= $past(cfg_reg.max_output_freq))
    else $error("target frequency above max frequency");

  a_main_only_mode: assert property (
    units == 4'h0 |=> target_freq == $past(x_freq))
    else $error("units 0 does not give main frequency");

  a_switch_aux_main: assert property (
    units == 4'h2 && sw_closed |=> target_freq == $past(y_indep))
    else $error("closed switch terminal does not give aux frequency");

  a_diff_floor_zero: assert property (
    units == 4'h1 && tens == 4'h1 && y_super > signed'({1'b0, x_freq}) &&
    cfg_reg.combine_offset_freq == '0 |=> target_freq == '0)
    else $error("negative difference not clamped to zero");

  sequence s_comb_write_bad;
    psel && !penable && pwrite && paddr == fsc_pkg::OFF_COMBINE &&
    pwdata[5:0] > fsc_pkg::COMB_MAX ##1 penable;
  endsequence
  a_combine_refused: assert property (
    s_comb_write_bad |-> pslverr ##1 $stable(cfg_reg.source_combine_select))
    else $error("out of range combine setting accepted");

  a_range_limit: assert property (
    cfg_reg.aux_range_percent <= fsc_pkg::PCT_MAX)
    else $error("aux range percent above 150");

  a_offset_limit: assert property (
    cfg_reg.combine_offset_freq <= cfg_reg.max_output_freq)
    else $error("offset frequency above max frequency");

  a_max_freq_span: assert property (
    cfg_reg.max_output_freq >= fsc_pkg::MAXF_MIN &&
    cfg_reg.max_output_freq <= fsc_pkg::MAXF_TOP)
    else $error("max frequency outside 50.00 to 500.00 Hz");

  sequence s_switch_steady;
    term_switch[*4];
  endsequence
  a_switch_sync: assert property (
    s_switch_steady |=> sw_closed)
    else $error("switch terminal not seen after synchroniser delay");
endmodule

// ==== test/fsc_src_model.sv ====
`timescale 1ns/10ps
module fsc_src_model (
  // clock
  input wire logic pclk,
  // levels asked for by the bench
  input wire logic [9:1][fsc_pkg::FRAC_W-1:0] frac_req,
  input wire logic signed [fsc_pkg::FREQ_W:0] adj_req,
  input wire logic sw_req,
  input wire logic men_req,
  input wire logic mot_req,
  // toward the block
  output logic [9:1][fsc_pkg::FRAC_W-1:0] chan_frac,
  output logic signed [fsc_pkg::FREQ_W:0] updown_adj,
  output logic term_switch,
  output logic term_motor_en,
  output logic term_motor
);
  ////////////////////////////////////////////////////////////////////////
  // channels and pins only move just after an edge, like real sources
  always @(posedge pclk) begin
    chan_frac <= frac_req;
    updown_adj <= adj_req;
    term_switch <= sw_req;
    term_motor_en <= men_req;
    term_motor <= mot_req;
  end
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [9:1][fsc_pkg::FRAC_W-1:0] frac_req = '0;
  logic [9:1][fsc_pkg::FRAC_W-1:0] chan_frac;
  logic signed [fsc_pkg::FREQ_W:0] adj_req = '0;
  logic signed [fsc_pkg::FREQ_W:0] updown_adj;
  logic sw_req = 1'b0;
  logic men_req = 1'b0;
  logic mot_req = 1'b0;
  logic term_switch;
  logic term_motor_en;
  logic term_motor;
  logic [15:0] target_freq;
  logic motor_bank;
  logic motor2_param_bank;
  logic [15:0] seed = 16'h0054;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int fr[1:9];
  int adj, mx, pre, offs, mcode, acode, units, tens, pct, rref, sw;

  always #5 pclk = ~pclk;

  fsc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_frac(chan_frac), .updown_adj(updown_adj),
    .term_switch(term_switch), .term_motor_en(term_motor_en), .term_motor(term_motor),
    .target_freq(target_freq), .motor_bank(motor_bank),
    .motor2_param_bank(motor2_param_bank));

  fsc_src_model u_src (.pclk(pclk), .frac_req(frac_req), .adj_req(adj_req),
    .sw_req(sw_req), .men_req(men_req), .mot_req(mot_req), .chan_frac(chan_frac),
    .updown_adj(updown_adj), .term_switch(term_switch), .term_motor_en(term_motor_en),
    .term_motor(term_motor));

  ////////////////////////////////////////////////////////////////////////
  function automatic int rnd(input int m);
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return int'(seed) % m;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // setup, then access held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic try_wr(input logic [7:0] a, input int d, input logic e);
    apb(1'b1, a, 32'(d));
    chk(32'(err), 32'(e));
  endtask

  ////////////////////////////////////////////////////////////////////////
  function automatic longint clampv(input longint v, input longint m);
    return (v < 0) ? 0 : ((v > m) ? m : v);
  endfunction

  function automatic longint src_val(input int code);
    if (code == 0) return clampv(pre + adj, mx);
    return longint'(fr[code]) * mx / 10000;
  endfunction

  function automatic longint exp_freq();
    longint x, yi, ys, c;
    x = src_val(mcode);
    yi = src_val(acode);
    ys = (acode == 0) ? adj : longint'(fr[acode]) * pct * (rref ? x : mx) / 1000000;
    case (tens)
      0: c = x + ys;
      1: c = x - ys;
      2: c = (x < ys) ? x : ys;
      default: c = (x > ys) ? x : ys;
    endcase
    c = c + offs;
    case (units)
      0: c = x;
      1: c = c;
      2: c = sw ? yi : x;
      3: c = sw ? c : x;
      default: c = sw ? c : yi;
    endcase
    return clampv(c, mx);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      summarize;
    end
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, fsc_pkg::OFF_RANGE, 32'h0);
    chk(rd, 32'h00000000);
    apb(1'b0, fsc_pkg::OFF_COMBINE, 32'h0);
    chk(rd, 32'h00000000);
    apb(1'b0, fsc_pkg::OFF_OFFSET, 32'h0);
    chk(rd, 32'h00000000);
    apb(1'b0, fsc_pkg::OFF_MAXF, 32'h0);
    chk(rd, 32'(fsc_pkg::MAXF_RST));
    apb(1'b0, fsc_pkg::OFF_SRC, 32'h0);
    chk(rd, 32'h00000000);
    // boundaries on each side of the range and combine limits, only the refused side of the max and offset limits
    try_wr(fsc_pkg::OFF_RANGE, 151, 1'b1);
    try_wr(fsc_pkg::OFF_RANGE, 150, 1'b0);
    try_wr(fsc_pkg::OFF_COMBINE, 35, 1'b1);
    try_wr(fsc_pkg::OFF_COMBINE, 5, 1'b1);
    try_wr(fsc_pkg::OFF_COMBINE, 34, 1'b0);
    try_wr(fsc_pkg::OFF_MAXF, 4999, 1'b1);
    try_wr(fsc_pkg::OFF_MAXF, 50001, 1'b1);
    try_wr(fsc_pkg::OFF_OFFSET, 5001, 1'b1);
    apb(1'b0, fsc_pkg::OFF_RANGE, 32'h0);
    chk(rd, 32'h00000096);
    apb(1'b0, fsc_pkg::OFF_COMBINE, 32'h0);
    chk(rd, 32'h00000022);
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[30:0], err}, 32'h00000001);
    // all eight stored/terminal combinations
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, fsc_pkg::OFF_MOTOR, 32'(m % 2));
      men_req <= m[1];
      mot_req <= m[2];
      repeat (8) @(posedge pclk);
      chk(32'(motor_bank), 32'(m[1] ? m[2] : m[0]));
      chk(32'(motor2_param_bank), 32'(m[1] ? m[2] : m[0]));
    end
    for (int i = 0; i < 200; i++) begin
      mx = rnd(45001) + 5000;
      pre = rnd(mx + 1);
      offs = rnd(mx + 1);
      adj = rnd(20001) - 10000;
      for (int k = 1; k < 10; k++) fr[k] = rnd(10001);
      mcode = rnd(10);
      acode = rnd(9);
      if (acode >= mcode) acode++;
      units = rnd(5);
      tens = rnd(4);
      pct = rnd(151);
      rref = rnd(2);
      sw = rnd(2);
      // walk every mode and operation with both switch levels first
      if (i < 40) begin
        units = i % 5;
        tens = (i / 5) % 4;
        sw = i / 20;
      end
      if (i % 9 == 0) begin
        pct = 150;
        offs = mx;
        if (acode != 0) fr[acode] = 10000;
      end
      apb(1'b1, fsc_pkg::OFF_MAXF, 32'(mx));
      apb(1'b1, fsc_pkg::OFF_OFFSET, 32'(offs));
      apb(1'b1, fsc_pkg::OFF_PRESET, 32'(pre));
      apb(1'b1, fsc_pkg::OFF_SRC, 32'(acode * 16 + mcode));
      apb(1'b1, fsc_pkg::OFF_RANGE, 32'(rref * 256 + pct));
      apb(1'b1, fsc_pkg::OFF_COMBINE, 32'(tens * 10 + units));
      for (int k = 1; k < 10; k++) frac_req[k] <= 14'(fr[k]);
      adj_req <= 17'(adj);
      sw_req <= sw[0];
      repeat (8) @(posedge pclk);
      chk(32'(target_freq), 32'(exp_freq()));
      apb(1'b0, fsc_pkg::OFF_STATUS, 32'h0);
      chk(rd & 32'h0000FFFF, 32'(exp_freq()));
      // motor terminal is still assigned from the bank walk, so it sets the bank
      chk(rd >> 16, 32'({men_req, sw[0], mot_req}));
      chk(32'(target_freq <= mx), 32'h1);
    end
    // reset in mid-run: outputs clear, settings return to their reset values
    presetn <= 1'b0;
    @(posedge pclk);
    chk(32'(target_freq), 32'h00000000);
    chk(32'(motor_bank), 32'h00000000);
    presetn <= 1'b1;
    apb(1'b0, fsc_pkg::OFF_MAXF, 32'h0);
    chk(rd, 32'(fsc_pkg::MAXF_RST));
    apb(1'b0, fsc_pkg::OFF_COMBINE, 32'h0);
    chk(rd, 32'h00000000);
    mx = int'(fsc_pkg::MAXF_RST);
    pre = int'(fsc_pkg::PRESET_RST);
    mcode = 0;
    acode = 0;
    units = 0;
    repeat (2) @(posedge pclk);
    chk(32'(target_freq), 32'(exp_freq()));
    summarize;
  end
endmodule
